// File: shared/ocp_pkg.sv
// Constants for the output compare and PWM channel
`default_nettype none
package ocp_pkg;
   // ==========================================================================
   // Register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_PRIMARY   = 8'h10;
   localparam logic [7:0] ADDR_SECONDARY = 8'h20;
   localparam logic [7:0] ADDR_EVENT_EN  = 8'h30;
   // ==========================================================================
   // Control and event enable field positions
   localparam int BIT_ON     = 15;
   localparam int BIT_STOP_IN_IDLE   = 13;
   localparam int BIT_WIDE   = 5;
   localparam int BIT_FAULT  = 4;
   localparam int BIT_TSEL   = 3;
   localparam int MODE_LSB   = 0;
   localparam int MODE_W     = 3;
   localparam int BIT_EVT_EN = 0;
   // ==========================================================================
   // Reset values
   localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
   localparam logic [31:0] VALUE_RESET = 32'h0000_0000;
   // ==========================================================================
   // Compare modes
   localparam logic [2:0] MODE_OFF      = 3'h0;
   localparam logic [2:0] MODE_SET_HIGH = 3'h1;
   localparam logic [2:0] MODE_SET_LOW  = 3'h2;
   localparam logic [2:0] MODE_TOGGLE   = 3'h3;
   localparam logic [2:0] MODE_SINGLE   = 3'h4;
   localparam logic [2:0] MODE_CONT     = 3'h5;
   localparam logic [2:0] MODE_PWM      = 3'h6;
   localparam logic [2:0] MODE_PWM_FLT  = 3'h7;
   // ==========================================================================
   // Fault input sharing
   localparam int LAST_FIRST_FAULT_CH = 4;
   localparam int MAX_CHANNEL         = 5;
   // ==========================================================================
   // Pulse sequencer for the pulse modes
   typedef enum logic [1:0] {PS_WAIT_RISE, PS_WAIT_FALL, PS_DONE} ocp_pulse_t;
endpackage : ocp_pkg
`default_nettype wire

// File: src/ocp_unit.sv
// Output compare channel with pulse and PWM modes and a register port
//
// How it works
// RULE_01: Compare values are matched against the selected timer; a match drives the mode action.
// RULE_02: Control bit 15 turns the whole channel on or off.
// RULE_03: Stop-in-idle bit 13 freezes the channel while the CPU idles.
// RULE_04: Bit 5 selects full 32-bit matching, otherwise the low 16 bits only.
// RULE_05: Fault flag bit 4 is set by a fault, cleared by hardware only; here any control register write clears it.
// RULE_06: Fault flag reads zero unless the mode is 111.
// RULE_07: Bit 3 picks the odd pair timer, clear picks the even one.
// RULE_08: Mode 001 starts the pin low and a match drives it high.
// RULE_09: Mode 010 starts the pin high and a match drives it low.
// RULE_10: Mode 011 inverts the pin on every match.
// RULE_11: Mode 100 starts low and makes exactly one pulse.
// RULE_12: Mode 101 starts low and makes a pulse every timer cycle.
// RULE_13: Mode 110 makes PWM and ignores the fault input.
// RULE_14: Mode 111 makes PWM; a fault disables the pin and sets the flag.
// RULE_15: Mode 000 disables the compare function.
// RULE_16: Channels one to four use the first fault input, five the second.
// RULE_17: A compare event can raise a request, gated by software.
// RULE_18: Time base is either 16-bit timer or both joined as 32 bits.
// RULE_19: Software avoids a register access right after clearing the enable bit.
// RULE_20: Control bits 31..16 and 12..6 always read zero.
// RULE_21: Pulse modes rise on the primary match and fall on the secondary.
// RULE_22: PWM copies secondary into primary at each period rollover; here no copy is made while the fault flag is set.
// RULE_23: After a fault the pin stays off until the mode field is rewritten.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`default_nettype none
module ocp_unit #(
   parameter int CHANNEL = 1,                      // Channel number, 1 to 5
   parameter int TW      = 16                      // Width of one timer
) (
   input  wire logic          clk,                 // Peripheral bus clock
   input  wire logic          resetn,              // Synchronous reset, active low
   input  wire logic [7:0]    reg_addr,            // Register byte address
   input  wire logic [31:0]   reg_wdata,           // Write data
   input  wire logic          reg_wr,              // Write strobe
   input  wire logic          reg_rd,              // Read strobe
   output logic      [31:0]   reg_rdata,           // Read data, cycle after strobe
   input  wire logic [TW-1:0] even_timer_count,    // Even pair timer count
   input  wire logic [TW-1:0] odd_timer_count,     // Odd pair timer count
   input  wire logic          even_timer_rollover, // Even timer period match pulse
   input  wire logic          odd_timer_rollover,  // Odd timer (or 32-bit) period pulse
   input  wire logic          cpu_idle,            // CPU is in Idle mode
   input  wire logic          fault_input_first,   // Fault, active high, channels 1..4
   input  wire logic          fault_input_second,  // Fault, active high, channel 5
   output logic               compare_output_pin,  // Compare output
   output logic               compare_event        // One-cycle compare request
);
   // ==========================================================================
   // Parameter checks
   if (CHANNEL < 1 || CHANNEL > ocp_pkg::MAX_CHANNEL) begin : g_bad_channel
      $error("CHANNEL must lie in 1..5");
   end
   if (TW != 16) begin : g_bad_width
      $error("TW must be 16 so that two timers form 32 bits");
   end

   localparam int CW = 2 * TW;

   // ==========================================================================
   // State
   logic             on_q, stop_in_idle_q, wide_q, tsel_q, fault_q, evt_en_q;
   logic [2:0]       mode_q;
   logic [CW-1:0]    prim_q, sec_q;
   logic             pin_q, evt_q;
   logic [31:0]      rdata_q;
   ocp_pkg::ocp_pulse_t ps_q, ps_d;

   // ==========================================================================
   // Decode
   wire wr_ctrl = reg_wr && (reg_addr == ocp_pkg::ADDR_CTRL);
   wire wr_prim = reg_wr && (reg_addr == ocp_pkg::ADDR_PRIMARY);
   wire wr_sec  = reg_wr && (reg_addr == ocp_pkg::ADDR_SECONDARY);
   wire wr_een  = reg_wr && (reg_addr == ocp_pkg::ADDR_EVENT_EN);
   wire [2:0] wmode = reg_wdata[ocp_pkg::MODE_LSB +: ocp_pkg::MODE_W];

   // Frozen in idle only when asked; otherwise idle is invisible
   wire run = on_q && !(stop_in_idle_q && cpu_idle); // RULE_02 RULE_03
   wire is_pwm = (mode_q == ocp_pkg::MODE_PWM) || (mode_q == ocp_pkg::MODE_PWM_FLT);
   wire is_pulse = (mode_q == ocp_pkg::MODE_SINGLE) || (mode_q == ocp_pkg::MODE_CONT);

   // Time base: even timer forms the low half of the joined 32-bit count
   wire [CW-1:0] tb_wide = {odd_timer_count, even_timer_count}; // RULE_18
   wire [TW-1:0] tb_narrow = tsel_q ? odd_timer_count : even_timer_count; // RULE_07
   wire [CW-1:0] tb = wide_q ? tb_wide : {{TW{1'b0}}, tb_narrow}; // RULE_04
   wire [CW-1:0] mask = wide_q ? {CW{1'b1}} : {{TW{1'b0}}, {TW{1'b1}}}; // RULE_04
   // Joined timer reports its period on the odd half
   wire rollover = (wide_q || tsel_q) ? odd_timer_rollover : even_timer_rollover;

   wire match_p = run && (mode_q != ocp_pkg::MODE_OFF) && ((prim_q & mask) == tb); // RULE_01
   wire match_s = run && (mode_q != ocp_pkg::MODE_OFF) && ((sec_q & mask) == tb); // RULE_01

   wire fault_sel = (CHANNEL <= ocp_pkg::LAST_FIRST_FAULT_CH) ?
                    fault_input_first : fault_input_second; // RULE_16
   wire fault_hit = run && (mode_q == ocp_pkg::MODE_PWM_FLT) && fault_sel; // RULE_14
   wire pwm_load = run && is_pwm && rollover && !fault_q; // RULE_22

   // ==========================================================================
   // Pulse sequencer for modes 100 and 101
   always_comb begin
      ps_d = ps_q;
      if (wr_ctrl) begin
         ps_d = ocp_pkg::PS_WAIT_RISE;
      end else if (is_pulse) begin
         unique case (ps_q)
            ocp_pkg::PS_WAIT_RISE: if (match_p) ps_d = ocp_pkg::PS_WAIT_FALL; // RULE_21
            ocp_pkg::PS_WAIT_FALL: begin
               if (match_s) begin // RULE_21
                  ps_d = (mode_q == ocp_pkg::MODE_CONT) ?
                         ocp_pkg::PS_WAIT_RISE : ocp_pkg::PS_DONE; // RULE_11 RULE_12
               end
            end
            ocp_pkg::PS_DONE:      ps_d = ocp_pkg::PS_DONE; // RULE_11
            default:               ps_d = ocp_pkg::PS_WAIT_RISE;
         endcase
      end
   end

   // ==========================================================================
   // Pin next value
   logic pin_d;
   always_comb begin
      pin_d = pin_q;
      if (wr_ctrl && !reg_wdata[ocp_pkg::BIT_ON]) begin
         pin_d = 1'b0; // RULE_02
      end else if (wr_ctrl) begin
         // Entry level of the newly written mode; toggle keeps its level
         pin_d = (wmode == ocp_pkg::MODE_SET_LOW) ? 1'b1 : // RULE_09
                 (wmode == ocp_pkg::MODE_TOGGLE)  ? pin_q : 1'b0; // RULE_08 RULE_11 RULE_12
      end else if (!on_q || mode_q == ocp_pkg::MODE_OFF) begin
         pin_d = 1'b0; // RULE_02 RULE_15
      end else if (fault_q || fault_hit) begin
         pin_d = 1'b0; // RULE_14 RULE_23
      end else begin
         unique case (mode_q)
            ocp_pkg::MODE_SET_HIGH: if (match_p) pin_d = 1'b1; // RULE_08
            ocp_pkg::MODE_SET_LOW:  if (match_p) pin_d = 1'b0; // RULE_09
            ocp_pkg::MODE_TOGGLE:   if (match_p) pin_d = !pin_q; // RULE_10
            ocp_pkg::MODE_SINGLE, ocp_pkg::MODE_CONT: begin
               if (ps_q == ocp_pkg::PS_WAIT_RISE && match_p) pin_d = 1'b1; // RULE_21
               else if (ps_q == ocp_pkg::PS_WAIT_FALL && match_s) pin_d = 1'b0; // RULE_21
            end
            ocp_pkg::MODE_PWM, ocp_pkg::MODE_PWM_FLT: begin
               // A zero duty keeps the pin low through the period
               if (pwm_load) pin_d = (sec_q & mask) != {CW{1'b0}}; // RULE_13 RULE_22
               else if (match_p) pin_d = 1'b0; // RULE_13
            end
            default: pin_d = 1'b0;
         endcase
      end
   end

   // Event raised on a mode 001/010/011 match, on the falling secondary match of a pulse and on a PWM rollover reload
   wire evt_raw = !fault_q && !wr_ctrl &&
                  (((mode_q == ocp_pkg::MODE_SET_HIGH || mode_q == ocp_pkg::MODE_SET_LOW ||
                     mode_q == ocp_pkg::MODE_TOGGLE) && match_p) ||
                   (is_pulse && ps_q == ocp_pkg::PS_WAIT_FALL && match_s) ||
                   (is_pwm && pwm_load));

   // ==========================================================================
   // Control register
   always_ff @(posedge clk) begin
      if (!resetn) begin
         on_q   <= ocp_pkg::CTRL_RESET[ocp_pkg::BIT_ON];
         stop_in_idle_q <= ocp_pkg::CTRL_RESET[ocp_pkg::BIT_STOP_IN_IDLE];
         wide_q <= ocp_pkg::CTRL_RESET[ocp_pkg::BIT_WIDE];
         tsel_q <= ocp_pkg::CTRL_RESET[ocp_pkg::BIT_TSEL];
         mode_q <= ocp_pkg::CTRL_RESET[ocp_pkg::MODE_LSB +: ocp_pkg::MODE_W];
      end else if (wr_ctrl) begin
         on_q   <= reg_wdata[ocp_pkg::BIT_ON];
         stop_in_idle_q <= reg_wdata[ocp_pkg::BIT_STOP_IN_IDLE];
         wide_q <= reg_wdata[ocp_pkg::BIT_WIDE];
         tsel_q <= reg_wdata[ocp_pkg::BIT_TSEL];
         mode_q <= wmode;
      end
   end

   // Fault flag: set wins over the clear done by a mode rewrite
   always_ff @(posedge clk) begin
      if (!resetn) begin
         fault_q <= 1'b0;
      end else if (fault_hit) begin
         fault_q <= 1'b1; // RULE_05 RULE_14
      end else if (wr_ctrl) begin
         fault_q <= 1'b0; // RULE_23
      end
   end

   // Software write beats a same-cycle rollover copy
   always_ff @(posedge clk) begin
      if (!resetn) begin
         prim_q <= ocp_pkg::VALUE_RESET;
      end else if (wr_prim) begin
         prim_q <= reg_wdata;
      end else if (pwm_load) begin
         prim_q <= sec_q; // RULE_22
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         sec_q    <= ocp_pkg::VALUE_RESET;
         evt_en_q <= 1'b0;
      end else begin
         if (wr_sec) sec_q <= reg_wdata;
         if (wr_een) evt_en_q <= reg_wdata[ocp_pkg::BIT_EVT_EN];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         pin_q <= 1'b0;
         evt_q <= 1'b0;
         ps_q  <= ocp_pkg::PS_WAIT_RISE;
      end else begin
         pin_q <= pin_d;
         evt_q <= evt_raw && evt_en_q; // RULE_17
         ps_q  <= ps_d;
      end
   end

   // ==========================================================================
   // Read path
   wire fault_vis = fault_q && (mode_q == ocp_pkg::MODE_PWM_FLT); // RULE_06
   wire [31:0] ctrl_view = {16'h0000, on_q, 1'b0, stop_in_idle_q, 7'h00, // RULE_20
                            wide_q, fault_vis, tsel_q, mode_q};
   wire [31:0] rd_mux = (reg_addr == ocp_pkg::ADDR_CTRL)      ? ctrl_view :
                        (reg_addr == ocp_pkg::ADDR_PRIMARY)   ? prim_q :
                        (reg_addr == ocp_pkg::ADDR_SECONDARY) ? sec_q :
                        (reg_addr == ocp_pkg::ADDR_EVENT_EN)  ? {31'h0000_0000, evt_en_q} :
                        32'h0000_0000;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   assign reg_rdata          = rdata_q;
   assign compare_output_pin = pin_q;
   assign compare_event      = evt_q;

   // ==========================================================================
   // Checks
   sequence s_rise;
      !wr_ctrl && mode_q == ocp_pkg::MODE_SET_HIGH && on_q && match_p;
   endsequence

   property p_set_high;
      @(posedge clk) disable iff (!resetn) s_rise |=> compare_output_pin;
   endproperty
   a_set_high: assert property (p_set_high) else $error("Mode 001 match did not set pin"); // RULE_08

   property p_set_low;
      @(posedge clk) disable iff (!resetn)
         (!wr_ctrl && on_q && mode_q == ocp_pkg::MODE_SET_LOW && match_p) |=> !compare_output_pin;
   endproperty
   a_set_low: assert property (p_set_low) else $error("Mode 010 match did not clear pin"); // RULE_09

   property p_toggle;
      @(posedge clk) disable iff (!resetn)
         (!wr_ctrl && on_q && mode_q == ocp_pkg::MODE_TOGGLE && match_p)
         |=> compare_output_pin != $past(compare_output_pin);
   endproperty
   a_toggle: assert property (p_toggle) else $error("Mode 011 match did not invert pin"); // RULE_10

   property p_entry_high;
      @(posedge clk) disable iff (!resetn)
         (wr_ctrl && reg_wdata[ocp_pkg::BIT_ON] && wmode == ocp_pkg::MODE_SET_LOW)
         |=> compare_output_pin;
   endproperty
   a_entry_high: assert property (p_entry_high) else $error("Mode 010 entry not high"); // RULE_09

   property p_single_done;
      @(posedge clk) disable iff (!resetn)
         (ps_q == ocp_pkg::PS_DONE && mode_q == ocp_pkg::MODE_SINGLE && !wr_ctrl)
         |=> !compare_output_pin;
   endproperty
   a_single_done: assert property (p_single_done) else $error("Second pulse in mode 100"); // RULE_11

   property p_fault_off;
      @(posedge clk) disable iff (!resetn)
         fault_hit |=> fault_q && !compare_output_pin;
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("Fault did not disable pin"); // RULE_14

   property p_fault_hold;
      @(posedge clk) disable iff (!resetn)
         (fault_q && !wr_ctrl) |=> fault_q && !compare_output_pin;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("Fault released without mode write"); // RULE_23

   property p_flag_hidden;
      @(posedge clk) disable iff (!resetn)
         (reg_rd && reg_addr == ocp_pkg::ADDR_CTRL && mode_q != ocp_pkg::MODE_PWM_FLT && !wr_ctrl)
         |=> !reg_rdata[ocp_pkg::BIT_FAULT] && reg_rdata[31:16] == 16'h0000
             && reg_rdata[12:6] == 7'h00;
   endproperty
   a_flag_hidden: assert property (p_flag_hidden) else $error("Hidden bits read nonzero"); // RULE_06

   property p_off_low;
      @(posedge clk) disable iff (!resetn)
         (!on_q && !wr_ctrl) [*2] |-> !compare_output_pin && !compare_event;
   endproperty
   a_off_low: assert property (p_off_low) else $error("Disabled channel drives pin"); // RULE_02

   property p_idle_freeze;
      @(posedge clk) disable iff (!resetn)
         (on_q && stop_in_idle_q && cpu_idle && !wr_ctrl && !wr_prim && !fault_q)
         |=> compare_output_pin == $past(compare_output_pin) && $stable(prim_q);
   endproperty
   a_idle_freeze: assert property (p_idle_freeze) else $error("Channel ran during idle"); // RULE_03

   property p_pwm_load;
      @(posedge clk) disable iff (!resetn)
         (pwm_load && !wr_prim) |=> prim_q == $past(sec_q);
   endproperty
   a_pwm_load: assert property (p_pwm_load) else $error("Duty not reloaded at rollover"); // RULE_22

   property p_event;
      @(posedge clk) disable iff (!resetn)
         compare_event |-> evt_en_q || $past(wr_een);
   endproperty
   a_event: assert property (p_event) else $error("Event raised while gated off"); // RULE_17

   sequence s_pulse_rise;
      !wr_ctrl && is_pulse && !fault_q && ps_q == ocp_pkg::PS_WAIT_RISE && match_p;
   endsequence

   property p_pulse_rise;
      @(posedge clk) disable iff (!resetn) s_pulse_rise |=> compare_output_pin;
   endproperty
   a_pulse_rise: assert property (p_pulse_rise) else $error("Pulse did not rise"); // RULE_21

   sequence s_pulse_fall;
      !wr_ctrl && is_pulse && !fault_q && ps_q == ocp_pkg::PS_WAIT_FALL && match_s;
   endsequence

   property p_pulse_fall;
      @(posedge clk) disable iff (!resetn) s_pulse_fall |=> !compare_output_pin;
   endproperty
   a_pulse_fall: assert property (p_pulse_fall) else $error("Pulse did not fall"); // RULE_21

   property p_mode_off;
      @(posedge clk) disable iff (!resetn)
         (on_q && mode_q == ocp_pkg::MODE_OFF && !wr_ctrl)
         |=> !compare_output_pin && !compare_event;
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("Mode 000 still drives pin"); // RULE_15
endmodule : ocp_unit
`default_nettype wire

// File: testbench/ocp_load.sv
// Load on the compare pin, source of both fault levels
`default_nettype none
module ocp_load (
   input  wire logic clk,        // Peripheral bus clock
   input  wire logic pin,        // Compare output seen by the load
   input  wire logic req_first,  // Bench asks for a first-input fault
   input  wire logic req_second, // Bench asks for a second-input fault
   output logic      flt_first,  // Fault level, channels one to four
   output logic      flt_second  // Fault level, channel five
);
   timeunit 1ns;
   timeprecision 1ns;
   // =========================================================================
   // Faults
   // Registered, so a trip lands just after an edge as a real comparator would
   initial begin
      flt_first = 1'b0;
      flt_second = 1'b0;
   end
   always @(posedge clk) begin
      flt_first  <= req_first;
      flt_second <= req_second;
   end
endmodule : ocp_load
`default_nettype wire

// File: testbench/ocp_unit_test.sv
// Self-checking bench for the output compare and PWM channel
`default_nettype none
module ocp_unit_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] ON = 32'h0000_8000;
   logic        clk;
   logic        resetn;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [15:0] cnt;
   logic        roll;
   logic        cpu_idle;
   logic        req_first;
   logic        req_second;
   logic        flt_first;
   logic        flt_second;
   logic        pin;
   logic        evt;
   logic [31:0] rdv;
   int          fails;
   int          total_checks;
   // =========================================================================
   // Time base: period of 64 counts, odd timer runs 8 ahead of the even one
   assign roll = (cnt == 16'h003f);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) cnt <= roll ? 16'h0000 : cnt + 16'h0001;
   ocp_unit dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .even_timer_count(cnt),
      .odd_timer_count(cnt + 16'h0008), .even_timer_rollover(roll),
      .odd_timer_rollover(roll), .cpu_idle(cpu_idle), .fault_input_first(flt_first),
      .fault_input_second(flt_second), .compare_output_pin(pin), .compare_event(evt));
   ocp_load load (.clk(clk), .pin(pin), .req_first(req_first), .req_second(req_second),
      .flt_first(flt_first), .flt_second(flt_second));
   // =========================================================================
   // Shared tasks
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      rdv = reg_rdata;
   endtask : rd
   // Control writes land at count 41, away from every compare value used
   task automatic ctrl(input logic [31:0] d);
      int i;
      for (i = 0; i < 70 && cnt !== 16'h0028; i++) @(negedge clk);
      if (i == 70) begin
         fails++;
         $display("BAD at %0t: count never reached 40", $time);
         end_of_test();
      end
      wr(ocp_pkg::ADDR_CTRL, d);
   endtask : ctrl
   task automatic wait_lvl(input logic lvl, input logic [15:0] ec, input logic ee);
      int i;
      for (i = 0; i < 200; i++) begin
         @(negedge clk);
         if (pin === lvl) break;
      end
      if (i == 200) begin
         fails++;
         $display("BAD at %0t: pin never reached %b", $time, lvl);
         end_of_test();
      end
      chk(cnt, ec);
      chk(evt, ee);
   endtask : wait_lvl
   task automatic hold_lvl(input logic lvl, input int n);
      int bad;
      bad = 0;
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         if (pin !== lvl) bad++;
      end
      chk(bad, 0);
   endtask : hold_lvl
   // =========================================================================
   // Scenarios
   task automatic t_regs();
      for (int k = 0; k < 5; k++) begin
         rd(8'(k * 16));
         chk(rdv, 32'h0000_0000);
      end
      wr(ocp_pkg::ADDR_CTRL, 32'hffff_ffff);
      rd(ocp_pkg::ADDR_CTRL);
      chk(rdv, 32'h0000_a02f);
      wr(ocp_pkg::ADDR_CTRL, 32'h0000_0000);
      wr(8'h40, 32'hffff_ffff);
      rd(8'h40);
      chk(rdv, 32'h0000_0000);
      wr(ocp_pkg::ADDR_PRIMARY, 32'h1234_0014);
      rd(ocp_pkg::ADDR_PRIMARY);
      chk(rdv, 32'h1234_0014);
      wr(ocp_pkg::ADDR_EVENT_EN, 32'h0000_0001);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_match();
      ctrl(ON | 32'h1);
      hold_lvl(1'b0, 2);
      wait_lvl(1'b1, 16'd21, 1'b1);
      wr(ocp_pkg::ADDR_EVENT_EN, 32'h0000_0000);
      ctrl(ON | 32'h2);
      hold_lvl(1'b1, 2);
      wait_lvl(1'b0, 16'd21, 1'b0);
      wr(ocp_pkg::ADDR_EVENT_EN, 32'h0000_0001);
      ctrl(ON | 32'hb);
      wait_lvl(1'b1, 16'd13, 1'b1);
      wait_lvl(1'b0, 16'd13, 1'b1);
      wr(ocp_pkg::ADDR_PRIMARY, 32'h0010_0009);
      ctrl(ON | 32'h21);
      hold_lvl(1'b0, 130);
      wr(ocp_pkg::ADDR_PRIMARY, 32'h0011_0009);
      wait_lvl(1'b1, 16'd10, 1'b1);
      $display("t_match done");
   endtask : t_match
   task automatic t_pulse();
      wr(ocp_pkg::ADDR_PRIMARY, 32'd10);
      wr(ocp_pkg::ADDR_SECONDARY, 32'd30);
      ctrl(ON | 32'h4);
      wait_lvl(1'b1, 16'd11, 1'b0);
      wait_lvl(1'b0, 16'd31, 1'b1);
      hold_lvl(1'b0, 130);
      ctrl(ON | 32'h5);
      wait_lvl(1'b1, 16'd11, 1'b0);
      wait_lvl(1'b0, 16'd31, 1'b1);
      wait_lvl(1'b1, 16'd11, 1'b0);
      $display("t_pulse done");
   endtask : t_pulse
   task automatic t_pwm();
      wr(ocp_pkg::ADDR_SECONDARY, 32'd16);
      ctrl(ON | 32'h6);
      wait_lvl(1'b1, 16'd0, 1'b1);
      req_first <= 1'b1;
      wait_lvl(1'b0, 16'd17, 1'b0);
      wait_lvl(1'b1, 16'd0, 1'b1);
      rd(ocp_pkg::ADDR_CTRL);
      chk(rdv, ON | 32'h6);
      req_first <= 1'b0;
      ctrl(ON | 32'h7);
      wait_lvl(1'b1, 16'd0, 1'b1);
      req_second <= 1'b1;
      wait_lvl(1'b0, 16'd17, 1'b0);
      req_second <= 1'b0;
      wait_lvl(1'b1, 16'd0, 1'b1);
      req_first <= 1'b1;
      wait_lvl(1'b0, 16'd2, 1'b0);
      rd(ocp_pkg::ADDR_CTRL);
      chk(rdv, ON | 32'h17);
      req_first <= 1'b0;
      wr(ocp_pkg::ADDR_SECONDARY, 32'd16);
      hold_lvl(1'b0, 130);
      rd(ocp_pkg::ADDR_CTRL);
      chk(rdv, ON | 32'h17);
      ctrl(ON | 32'h7);
      rd(ocp_pkg::ADDR_CTRL);
      chk(rdv, ON | 32'h7);
      wait_lvl(1'b1, 16'd0, 1'b1);
      $display("t_pwm done");
   endtask : t_pwm
   task automatic t_idle();
      @(posedge clk);
      cpu_idle <= 1'b1;
      ctrl(ON | 32'h2003);
      wr(ocp_pkg::ADDR_PRIMARY, 32'd20);
      hold_lvl(1'b0, 130);
      ctrl(ON | 32'h3);
      wait_lvl(1'b1, 16'd21, 1'b1);
      @(posedge clk);
      cpu_idle <= 1'b0;
      $display("t_idle done");
   endtask : t_idle
   task automatic t_off();
      ctrl(ON | 32'h2);
      hold_lvl(1'b1, 2);
      ctrl(32'h2);
      hold_lvl(1'b0, 70);
      ctrl(ON | 32'h2);
      hold_lvl(1'b1, 2);
      ctrl(ON);
      hold_lvl(1'b0, 70);
      $display("t_off done");
   endtask : t_off
   initial begin
      resetn = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      cnt = 16'h0000;
      cpu_idle = 1'b0;
      req_first = 1'b0;
      req_second = 1'b0;
      fails = 0;
      total_checks = 0;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      chk(pin, 1'b0);
      t_regs();
      t_match();
      t_pulse();
      t_pwm();
      t_idle();
      t_off();
      end_of_test();
   end
endmodule : ocp_unit_test
`default_nettype wire
